/* File: verilog/edm_monitor.sv */
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "edm_regs.svh"
module edm_monitor (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire edm_pkg::edm_bus_t bus_i,
    output logic [31:0] rdata_o,
    input wire logic fifo_drop_i,
    input wire logic nobuf_flush_i,
    input wire logic rx_frame_done_i,
    input wire logic delayed_interrupt_request_i,
    input wire logic normal_interrupt_summary_enable_i,
    input wire logic ptr_tx_desc_we_i,
    input wire logic ptr_rx_desc_we_i,
    input wire logic ptr_tx_buf_we_i,
    input wire logic ptr_rx_buf_we_i,
    input wire edm_pkg::edm_ptrs_t ptr_i,
    output logic receive_complete_status_o,
    output logic irq_o
);
    logic [10:0] fifo_dropped_frame_count_ff;
    logic [15:0] no_buffer_missed_frame_count_ff;
    logic [7:0] rx_status_delay_value_ff;
    edm_pkg::edm_ptrs_t ptr_ff;
    edm_pkg::edm_wd_state_t wd_state_ff;
    logic [15:0] wd_cnt_ff;
    logic [2:0] int_stat_ff;
    logic [2:0] int_mask_ff;
    logic rx_status_set;
    logic rd_missed;

    // write hit decode
    function automatic logic hit_wr(input edm_pkg::edm_bus_t b, input logic [15:0] off);
        return b.wr && (b.addr == off);
    endfunction : hit_wr

    assign rd_missed = bus_i.rd && (bus_i.addr == `EDM_OFF_MISSED);

    // fifo drop counter, clear on read, event wins over clear
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            fifo_dropped_frame_count_ff <= '0;
        end
        else if (rd_missed)
        begin
            fifo_dropped_frame_count_ff <= {10'h000, fifo_drop_i};
        end
        else if (fifo_drop_i)
        begin
            fifo_dropped_frame_count_ff <= fifo_dropped_frame_count_ff + 11'h001;
        end
    end

    // no-buffer counter
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            no_buffer_missed_frame_count_ff <= '0;
        end
        else if (rd_missed)
        begin
            no_buffer_missed_frame_count_ff <= {15'h0000, nobuf_flush_i};
        end
        else if (nobuf_flush_i)
        begin
            no_buffer_missed_frame_count_ff <= no_buffer_missed_frame_count_ff + 16'h0001;
        end
    end

    // watchdog value register; reserved bits ignored
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rx_status_delay_value_ff <= '0;
        end
        else if (hit_wr(bus_i, `EDM_OFF_WDOG) && bus_i.be[0])
        begin
            rx_status_delay_value_ff <= bus_i.wdata[`EDM_WDOG_MSB:0];
        end
    end

    // live pointers loaded by the dma engines
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ptr_ff <= '0;
        end
        else
        begin
            if (ptr_tx_desc_we_i)
            begin
                ptr_ff.tx_desc <= ptr_i.tx_desc;
            end
            if (ptr_rx_desc_we_i)
            begin
                ptr_ff.rx_desc <= ptr_i.rx_desc;
            end
            if (ptr_tx_buf_we_i)
            begin
                ptr_ff.tx_buf <= ptr_i.tx_buf;
            end
            if (ptr_rx_buf_we_i)
            begin
                ptr_ff.rx_buf <= ptr_i.rx_buf;
            end
        end
    end

    // receive status watchdog: delay value*256 cycles when requested
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            wd_state_ff <= edm_pkg::EDM_IDLE;
            wd_cnt_ff <= '0;
        end
        else
        begin
            unique case (wd_state_ff)
                edm_pkg::EDM_IDLE:
                begin
                    if (rx_frame_done_i && delayed_interrupt_request_i
                        && (rx_status_delay_value_ff != 8'h00))
                    begin
                        wd_state_ff <= edm_pkg::EDM_WAIT;
                        wd_cnt_ff <= {rx_status_delay_value_ff, 8'h00} - 16'h0001;
                    end
                end
                edm_pkg::EDM_WAIT:
                begin
                    if (wd_cnt_ff == 16'h0000)
                    begin
                        wd_state_ff <= edm_pkg::EDM_IDLE;
                    end
                    else
                    begin
                        wd_cnt_ff <= wd_cnt_ff - 16'h0001;
                    end
                end
                default:
                begin
                    wd_state_ff <= edm_pkg::EDM_IDLE;
                end
            endcase
        end
    end

    // immediate when idle and no delay requested or value zero; a frame done while waiting sets no status
    assign rx_status_set = (wd_state_ff == edm_pkg::EDM_WAIT && wd_cnt_ff == 16'h0000)
        || (wd_state_ff == edm_pkg::EDM_IDLE && rx_frame_done_i
            && (!delayed_interrupt_request_i || rx_status_delay_value_ff == 8'h00));

    // sticky status, set beats write-one clear
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            int_stat_ff <= '0;
        end
        else
        begin
            int_stat_ff <= (int_stat_ff & ~((hit_wr(bus_i, `EDM_OFF_INT_STAT) && bus_i.be[0])
                ? bus_i.wdata[2:0] : 3'h0))
                | {fifo_drop_i, nobuf_flush_i, rx_status_set};
        end
    end

    // interrupt mask
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            int_mask_ff <= '0;
        end
        else if (hit_wr(bus_i, `EDM_OFF_INT_MASK) && bus_i.be[0])
        begin
            int_mask_ff <= bus_i.wdata[2:0];
        end
    end

    // outputs registered
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            receive_complete_status_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            receive_complete_status_o <= int_stat_ff[`EDM_INT_RX_DONE];
            irq_o <= ((int_stat_ff[2:1] & int_mask_ff[2:1]) != 2'h0)
                || (int_stat_ff[0] && int_mask_ff[0]
                    && normal_interrupt_summary_enable_i);
        end
    end

    // read data one cycle later; unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rdata_o <= `EDM_RST_WORD;
        end
        else if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                `EDM_OFF_MISSED:
                    rdata_o <= {4'h0, fifo_dropped_frame_count_ff, 1'b0,
                                no_buffer_missed_frame_count_ff};
                `EDM_OFF_WDOG: rdata_o <= {24'h00_0000, rx_status_delay_value_ff};
                `EDM_OFF_TXDESC: rdata_o <= ptr_ff.tx_desc;
                `EDM_OFF_RXDESC: rdata_o <= ptr_ff.rx_desc;
                `EDM_OFF_TXBUF: rdata_o <= ptr_ff.tx_buf;
                `EDM_OFF_RXBUF: rdata_o <= ptr_ff.rx_buf;
                `EDM_OFF_INT_STAT: rdata_o <= {29'h0000_0000, int_stat_ff};
                `EDM_OFF_INT_MASK: rdata_o <= {29'h0000_0000, int_mask_ff};
                default: rdata_o <= `EDM_RST_WORD;
            endcase
        end
        else
        begin
            rdata_o <= `EDM_RST_WORD;
        end
    end

    // counter counts one per flush
    property p_nobuf_inc;
        @(posedge clk_i) disable iff (!rst_n_i)
        (nobuf_flush_i && !rd_missed)
        |=> no_buffer_missed_frame_count_ff == $past(no_buffer_missed_frame_count_ff) + 16'h0001;
    endproperty
    a_nobuf_inc: assert property (p_nobuf_inc) else $error("no-buffer count not incremented");

    property p_read_clear;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rd_missed && !nobuf_flush_i && !fifo_drop_i)
        |=> (no_buffer_missed_frame_count_ff == 16'h0000)
            && (fifo_dropped_frame_count_ff == 11'h000);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("counters not cleared on read");

    property p_fifo_inc;
        @(posedge clk_i) disable iff (!rst_n_i)
        (fifo_drop_i && !rd_missed)
        |=> fifo_dropped_frame_count_ff == $past(fifo_dropped_frame_count_ff) + 11'h001;
    endproperty
    a_fifo_inc: assert property (p_fifo_inc) else $error("fifo drop count wrong");

    // helper: cycles spent waiting since the delayed frame was taken
    logic [15:0] dly_age_ff;
    logic [7:0] dly_val_ff;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            dly_age_ff <= '0;
            dly_val_ff <= '0;
        end
        else if (wd_state_ff == edm_pkg::EDM_IDLE)
        begin
            dly_age_ff <= 16'h0001;
            dly_val_ff <= rx_status_delay_value_ff;
        end
        else
        begin
            dly_age_ff <= dly_age_ff + 16'h0001;
        end
    end

    sequence s_delay_start;
        wd_state_ff == edm_pkg::EDM_IDLE && rx_frame_done_i && delayed_interrupt_request_i
        && rx_status_delay_value_ff != 8'h00;
    endsequence
    property p_delay_256;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_delay_start |=> (wd_state_ff == edm_pkg::EDM_WAIT) && !rx_status_set;
    endproperty
    a_delay_256: assert property (p_delay_256) else $error("status delay not started");

    // status comes exactly when the wait reaches value times 256 cycles
    property p_delay_end;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wd_state_ff == edm_pkg::EDM_WAIT)
        |-> (rx_status_set == (dly_age_ff == {dly_val_ff, 8'h00}));
    endproperty
    a_delay_end: assert property (p_delay_end) else $error("status delay length wrong");

    property p_no_delay;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wd_state_ff == edm_pkg::EDM_IDLE && rx_frame_done_i && !delayed_interrupt_request_i)
        |-> rx_status_set;
    endproperty
    a_no_delay: assert property (p_no_delay) else $error("undelayed status missing");

    property p_wdog_rw;
        @(posedge clk_i) disable iff (!rst_n_i)
        (hit_wr(bus_i, `EDM_OFF_WDOG) && bus_i.be[0])
        |=> rx_status_delay_value_ff == $past(bus_i.wdata[7:0]);
    endproperty
    a_wdog_rw: assert property (p_wdog_rw) else $error("watchdog value not written");

    property p_ptr_rx_desc;
        @(posedge clk_i) disable iff (!rst_n_i)
        ptr_rx_desc_we_i |=> ptr_ff.rx_desc == $past(ptr_i.rx_desc);
    endproperty
    a_ptr_rx_desc: assert property (p_ptr_rx_desc) else $error("rx descriptor ptr stale");

    property p_irq_gate;
        @(posedge clk_i) disable iff (!rst_n_i)
        (int_stat_ff == 3'h1 && !normal_interrupt_summary_enable_i) |=> !irq_o;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("receive irq not gated");
endmodule : edm_monitor

/* File: verilog/edm_regs.svh */
`ifndef EDM_REGS_SVH
`define EDM_REGS_SVH
`define EDM_OFF_MISSED 16'h1020
`define EDM_OFF_WDOG 16'h1024
`define EDM_OFF_TXDESC 16'h1048
`define EDM_OFF_RXDESC 16'h104c
`define EDM_OFF_TXBUF 16'h1050
`define EDM_OFF_RXBUF 16'h1054
`define EDM_OFF_INT_STAT 16'h1100
`define EDM_OFF_INT_MASK 16'h1104
`define EDM_FIFO_CNT_LSB 17
`define EDM_FIFO_CNT_MSB 27
`define EDM_NOBUF_CNT_MSB 15
`define EDM_WDOG_MSB 7
`define EDM_WDOG_UNIT 8
`define EDM_RST_WORD 32'h0000_0000
`define EDM_INT_RX_DONE 0
`define EDM_INT_NOBUF 1
`define EDM_INT_FIFO_DROP 2
`endif

/* File: verilog/edm_pkg.sv */
package edm_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic wr;
        logic rd;
    } edm_bus_t;

    typedef struct packed {
        logic [31:0] tx_desc;
        logic [31:0] rx_desc;
        logic [31:0] tx_buf;
        logic [31:0] rx_buf;
    } edm_ptrs_t;

    typedef enum logic [1:0] {
        EDM_IDLE,
        EDM_WAIT
    } edm_wd_state_t;
endpackage : edm_pkg

/* File: verif/edm_far_model.sv */
`timescale 1ns/1ps
// receive fifo and dma side: event pulses and live pointer loads
module edm_far_model (
    input wire logic clk_i,
    output logic fifo_drop_o,
    output logic nobuf_flush_o,
    output logic frame_done_o,
    output logic dir_o,
    output logic [3:0] ptr_we_o,
    output edm_pkg::edm_ptrs_t ptr_o
);
    // quiet outputs at time zero
    initial
    begin
        fifo_drop_o = 1'b0;
        nobuf_flush_o = 1'b0;
        frame_done_o = 1'b0;
        dir_o = 1'b0;
        ptr_we_o = 4'h0;
        ptr_o = '0;
    end

    // n one-cycle events of one kind, each followed by a gap
    task automatic frames(input int kind, input int n, input logic dly);
        repeat (n)
        begin
            @(posedge clk_i);
            fifo_drop_o <= (kind == 0);
            nobuf_flush_o <= (kind == 1);
            frame_done_o <= (kind == 2);
            dir_o <= dly; // descriptor delay bit travels with done
            @(posedge clk_i);
            fifo_drop_o <= 1'b0;
            nobuf_flush_o <= 1'b0;
            frame_done_o <= 1'b0;
            dir_o <= ~dly;
        end
    endtask : frames

    // load all four pointers, then scramble the idle bus
    task automatic load(input edm_pkg::edm_ptrs_t v);
        @(posedge clk_i);
        ptr_o <= v;
        ptr_we_o <= 4'hf;
        @(posedge clk_i);
        ptr_we_o <= 4'h0;
        ptr_o <= ~v; // stale value must not look valid
    endtask : load
endmodule : edm_far_model

/* File: verif/tb_enet_dma_monitor_pointers.sv */
`timescale 1ns/1ps
`include "edm_regs.svh"
module tb_enet_dma_monitor_pointers;
    logic clk_i;
    logic rst_n_i;
    logic sum_en;
    logic rd_pend;
    logic [31:0] rdata_o;
    logic stat_o;
    logic irq_o;
    logic fd, nb, done, dir;
    logic [3:0] we;
    logic [7:0] v;
    logic [15:0] n, m;
    edm_pkg::edm_bus_t bus;
    edm_pkg::edm_ptrs_t ptr, p;
    logic [31:0] exp_q [$];
    int err_total;
    int samples_checked;
    logic [15:0] offs [7] = '{`EDM_OFF_MISSED, `EDM_OFF_WDOG, `EDM_OFF_TXDESC,
        `EDM_OFF_RXDESC, `EDM_OFF_TXBUF, `EDM_OFF_RXBUF, 16'h1200};

    edm_monitor dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata_o),
        .fifo_drop_i(fd), .nobuf_flush_i(nb), .rx_frame_done_i(done),
        .delayed_interrupt_request_i(dir), .normal_interrupt_summary_enable_i(sum_en),
        .ptr_tx_desc_we_i(we[0]), .ptr_rx_desc_we_i(we[1]), .ptr_tx_buf_we_i(we[2]),
        .ptr_rx_buf_we_i(we[3]), .ptr_i(ptr), .receive_complete_status_o(stat_o),
        .irq_o(irq_o));
    edm_far_model far (.clk_i(clk_i), .fifo_drop_o(fd), .nobuf_flush_o(nb),
        .frame_done_o(done), .dir_o(dir), .ptr_we_o(we), .ptr_o(ptr));

    // 100 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: read %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk1

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge clk_i);
        bus <= '{a, d, b, 1'b1, 1'b0};
        @(posedge clk_i);
        bus <= '0;
    endtask : wr

    // read request; expectation noted for the watcher
    task automatic rdx(input logic [15:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clk_i);
        bus <= '{a, 32'h0000_0000, 4'hf, 1'b0, 1'b1};
        @(posedge clk_i);
        bus <= '0;
    endtask : rdx

    task automatic idle(input int k);
        repeat (k) @(negedge clk_i);
    endtask : idle

    // read data stand only in the cycle after the strobe
    always @(posedge clk_i) rd_pend <= bus.rd;
    always @(negedge clk_i)
    begin
        if (rd_pend === 1'b1 && exp_q.size() > 0)
            chk32(rdata_o, exp_q.pop_front());
    end

    task automatic final_report();
        $display("mismatches %0d, comparisons %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    // hang guard, far beyond the several hundred cycles of the tests
    initial
    begin
        #200000;
        err_total++;
        final_report();
    end

    initial
    begin
        bus = '0;
        rst_n_i = 1'b0;
        sum_en = 1'b0;
        err_total = 0;
        samples_checked = 0;
        void'($urandom(66201));
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // writes to read-only and unmapped places are ignored
        for (int i = 2; i < 7; i++) wr(offs[i], $urandom, 4'hf);
        for (int i = 0; i < 7; i++) rdx(offs[i], `EDM_RST_WORD);
        p = {$urandom, $urandom, $urandom, $urandom};
        far.load(p);
        rdx(`EDM_OFF_TXDESC, p.tx_desc);
        rdx(`EDM_OFF_RXDESC, p.rx_desc);
        rdx(`EDM_OFF_TXBUF, p.tx_buf);
        rdx(`EDM_OFF_RXBUF, p.rx_buf);
        // watchdog value through byte, half-word and foreign lanes
        v = 8'($urandom);
        wr(`EDM_OFF_WDOG, {24'h0, v}, 4'h1);
        rdx(`EDM_OFF_WDOG, {24'h0, v});
        wr(`EDM_OFF_WDOG, {24'h0, ~v}, 4'h2);
        rdx(`EDM_OFF_WDOG, {24'h0, v});
        v = ~v;
        wr(`EDM_OFF_WDOG, {24'h0, v}, 4'h3);
        rdx(`EDM_OFF_WDOG, {24'h0, v});
        // missed-frame counts, read clears them
        n = 16'($urandom_range(1, 6));
        m = 16'($urandom_range(1, 6));
        far.frames(0, n, 1'b0);
        far.frames(1, m, 1'b0);
        rdx(`EDM_OFF_MISSED, {4'h0, n[10:0], 1'b0, m});
        rdx(`EDM_OFF_MISSED, `EDM_RST_WORD);
        rdx(`EDM_OFF_INT_STAT, 32'h0000_0006);
        wr(`EDM_OFF_INT_STAT, 32'h0000_0006, 4'h1);
        rdx(`EDM_OFF_INT_STAT, `EDM_RST_WORD);
        chk1(irq_o, 1'b0);
        // delayed receive status: 2 x 256 clocks
        wr(`EDM_OFF_WDOG, 32'h0000_0002, 4'h1);
        wr(`EDM_OFF_INT_MASK, 32'h0000_0001, 4'h1);
        sum_en <= 1'b1;
        far.frames(2, 1, 1'b1);
        // status bit at 512 cycles, output one edge later
        idle(513);
        chk1(stat_o, 1'b0);
        idle(1);
        chk1(stat_o, 1'b1);
        chk1(irq_o, 1'b1);
        wr(`EDM_OFF_INT_MASK, `EDM_RST_WORD, 4'h1);
        idle(3);
        chk1(irq_o, 1'b0);
        wr(`EDM_OFF_INT_MASK, 32'h0000_0001, 4'h1);
        sum_en <= 1'b0;
        idle(3);
        chk1(irq_o, 1'b0);
        @(posedge clk_i);
        sum_en <= 1'b1;
        wr(`EDM_OFF_INT_STAT, 32'h0000_0001, 4'h1);
        idle(3);
        chk1(stat_o, 1'b0);
        // no delay request: value is ignored
        far.frames(2, 1, 1'b0);
        idle(4);
        chk1(stat_o, 1'b1);
        rdx(`EDM_OFF_INT_STAT, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        final_report();
    end
endmodule : tb_enet_dma_monitor_pointers
